// File: audio_pin_pkg.sv
// constants for the audio port clock and frame-sync pin block
package audio_pin_pkg;
  // apb register byte offsets
  localparam logic [7:0] OFS_PIN_MODE = 8'h00;
  localparam logic [7:0] OFS_GPIO_DIR = 8'h04;
  localparam logic [7:0] OFS_GPIO_OUT = 8'h08;
  localparam logic [7:0] OFS_PORT_CTRL = 8'h0C;
  localparam logic [7:0] OFS_FLAG_CTRL = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  // pin index inside 6-bit pin vectors
  localparam int PIN_RX_BCLK = 0;
  localparam int PIN_RX_FSYNC = 1;
  localparam int PIN_RX_HFCLK = 2;
  localparam int PIN_TX_FSYNC = 4;
  localparam int PIN_TX_HFCLK = 5;
  localparam int NUM_PINS = 6;
  // port_ctrl fields
  localparam int POS_SYNC = 0;
  localparam int POS_TX_BUF_SEL = 1;
  localparam int POS_RX_FS_DIR = 2;
  localparam int POS_TX_FS_DIR = 3;
  localparam int POS_NETWORK = 4;
  localparam int POS_RX_HF_DIR = 5;
  localparam int POS_TX_HF_DIR = 6;
  localparam int POS_RX_BCLK_DIR = 7;
  // flag_ctrl fields
  localparam int POS_OUT_FLAG_ZERO = 0;
  localparam int POS_OUT_FLAG_ONE = 1;
  // status fields
  localparam int POS_IN_FLAG_ZERO = 0;
  localparam int POS_IN_FLAG_ONE = 1;
  localparam int POS_RX_SRC = 2;
  localparam int POS_TX_SRC = 3;
  // reset values
  localparam logic [5:0] RST_PINS = 6'h00;
  localparam logic [7:0] RST_PORT_CTRL = 8'h00;
  // high-frequency clock output divider, half period minus one in link_clk cycles
  localparam logic [3:0] HF_HALF_DIV = 4'h1;
  localparam logic [31:0] RD_UNMAPPED = 32'h00000000;
endpackage

// File: audio_pin_ctrl.sv
// pin control for the audio port high-frequency clock and frame-sync pins
`timescale 1ns/1ps
// Summary of operation
// - rx hf clock input selects rx clock source
// - rx hf clock output drives divided clock
// - tx hf clock input selects tx clock source
// - tx hf clock output drives divided clock
// - gpio pins individually input, output, disconnected; direction bit gives only driven or undriven, no gpio input data register
// - all pins gpio disconnected after reset
// - async mode rx frame sync for receivers
// - sync mode rx fsync is flag or buffer enable
// - serial flag one direction follows rx fsync direction, flag zero follows rx bclk direction
// - output flag one updated on frame or slot
// - input flag one captured on frame or slot
// - sync mode tx fsync shared by both
// - async mode tx fsync for transmitters only
// - tx fsync direction from its direction bit
// - rx bit clock is clock or flag zero
module audio_pin_ctrl (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic link_clk,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [audio_pin_pkg::NUM_PINS-1:0] pin_in,
  output logic [audio_pin_pkg::NUM_PINS-1:0] pin_out,
  output logic [audio_pin_pkg::NUM_PINS-1:0] pin_oe,
  input wire logic rx_fsync_int,
  input wire logic tx_fsync_int,
  input wire logic rx_bclk_int,
  input wire logic slot_strobe,
  input wire logic tx_buf_enable,
  output logic rx_fsync_ext,
  output logic tx_fsync_ext,
  output logic rx_bclk_ext,
  output logic rx_clk_sel_ext,
  output logic tx_clk_sel_ext
);
  import audio_pin_pkg::*;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [5:0] pin_mode_reg;
  logic [5:0] gpio_dir_reg;
  logic [5:0] gpio_out_reg;
  logic [7:0] port_ctrl_reg;
  logic [1:0] flag_ctrl_reg;
  logic [1:0] in_flag_reg;
  logic [5:0] sync1_reg;
  logic [5:0] sync2_reg;
  logic [5:0] pin_out_next;
  logic [5:0] pin_oe_next;
  logic frame_tick;
  logic fs_prev_reg;
  logic [1:0] flag_out_reg;
  logic [3:0] hf_cnt_reg;
  logic hf_clk_reg;
  logic hf_sync1_reg;
  logic hf_sync2_reg;
  logic wr_en;
  logic rd_en;
  logic sync_mode;

  assign sync_mode = port_ctrl_reg[POS_SYNC];

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  assign wr_en = psel && penable && pwrite && pready;
  assign rd_en = psel && !penable && !pwrite;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && !penable;
    end
  end

  // error stands only beside pready
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= psel && !penable && ((paddr > OFS_STATUS) || (paddr[1:0] != 2'b00));
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= RD_UNMAPPED;
    end else if (rd_en) begin
      case (paddr)
        OFS_PIN_MODE: prdata <= {26'h0, pin_mode_reg};
        OFS_GPIO_DIR: prdata <= {26'h0, gpio_dir_reg};
        OFS_GPIO_OUT: prdata <= {26'h0, gpio_out_reg};
        OFS_PORT_CTRL: prdata <= {24'h0, port_ctrl_reg};
        OFS_FLAG_CTRL: prdata <= {30'h0, flag_ctrl_reg};
        OFS_STATUS: prdata <= {28'h0,
          port_ctrl_reg[POS_TX_HF_DIR] ? 1'b0 : pin_mode_reg[PIN_TX_HFCLK],
          port_ctrl_reg[POS_RX_HF_DIR] ? 1'b0 : pin_mode_reg[PIN_RX_HFCLK], in_flag_reg};
        default: prdata <= RD_UNMAPPED;
      endcase
    end
  end

  // per-pin mode, direction and data, reset to disconnected
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pin_mode_reg <= RST_PINS;
      gpio_dir_reg <= RST_PINS;
      gpio_out_reg <= RST_PINS;
      port_ctrl_reg <= RST_PORT_CTRL;
      flag_ctrl_reg <= 2'b00;
    end else if (wr_en && !pslverr) begin
      case (paddr)
        OFS_PIN_MODE: pin_mode_reg <= pwdata[5:0];
        OFS_GPIO_DIR: gpio_dir_reg <= pwdata[5:0];
        OFS_GPIO_OUT: gpio_out_reg <= pwdata[5:0];
        OFS_PORT_CTRL: port_ctrl_reg <= pwdata[7:0];
        OFS_FLAG_CTRL: flag_ctrl_reg <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // pin input synchronisers
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sync1_reg <= 6'h00;
      sync2_reg <= 6'h00;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
    end
  end

  // ----------------------------------------
  // serial flags on frame or slot
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      fs_prev_reg <= 1'b0;
    end else begin
      fs_prev_reg <= tx_fsync_int;
    end
  end

  assign frame_tick = port_ctrl_reg[POS_NETWORK] ? slot_strobe : (tx_fsync_int && !fs_prev_reg);

  // flag one and zero updated on frame or slot
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      flag_out_reg <= 2'b00;
      in_flag_reg <= 2'b00;
    end else if (frame_tick) begin
      flag_out_reg <= flag_ctrl_reg;
      in_flag_reg <= {sync2_reg[PIN_RX_FSYNC], sync2_reg[PIN_RX_BCLK]};
    end
  end

  // ----------------------------------------
  // high-frequency clock out, link clock domain
  // ----------------------------------------
  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      hf_cnt_reg <= 4'h0;
      hf_clk_reg <= 1'b0;
    end else if (hf_cnt_reg == HF_HALF_DIV) begin
      hf_cnt_reg <= 4'h0;
      hf_clk_reg <= !hf_clk_reg;
    end else begin
      hf_cnt_reg <= hf_cnt_reg + 4'h1;
    end
  end

  // two-flop crossing of the hf clock into clk_sys
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      hf_sync1_reg <= 1'b0;
      hf_sync2_reg <= 1'b0;
    end else begin
      hf_sync1_reg <= hf_clk_reg;
      hf_sync2_reg <= hf_sync1_reg;
    end
  end

  // ----------------------------------------
  // pin muxing
  // ----------------------------------------
  always_comb begin
    pin_out_next = 6'h00;
    pin_oe_next = 6'h00;
    for (int i = 0; i < NUM_PINS; i++) begin
      if (!pin_mode_reg[i]) begin
        pin_out_next[i] = gpio_out_reg[i];
        pin_oe_next[i] = gpio_dir_reg[i];
      end
    end
    if (pin_mode_reg[PIN_RX_HFCLK]) begin
      pin_out_next[PIN_RX_HFCLK] = hf_sync2_reg;
      pin_oe_next[PIN_RX_HFCLK] = port_ctrl_reg[POS_RX_HF_DIR];
    end
    if (pin_mode_reg[PIN_TX_HFCLK]) begin
      pin_out_next[PIN_TX_HFCLK] = hf_sync2_reg;
      pin_oe_next[PIN_TX_HFCLK] = port_ctrl_reg[POS_TX_HF_DIR];
    end
    if (pin_mode_reg[PIN_TX_FSYNC]) begin
      pin_out_next[PIN_TX_FSYNC] = tx_fsync_int;
      pin_oe_next[PIN_TX_FSYNC] = port_ctrl_reg[POS_TX_FS_DIR];
    end
    if (pin_mode_reg[PIN_RX_BCLK]) begin
      pin_out_next[PIN_RX_BCLK] = sync_mode ? flag_out_reg[0] : rx_bclk_int;
      pin_oe_next[PIN_RX_BCLK] = port_ctrl_reg[POS_RX_BCLK_DIR];
    end
    if (pin_mode_reg[PIN_RX_FSYNC]) begin
      pin_oe_next[PIN_RX_FSYNC] = port_ctrl_reg[POS_RX_FS_DIR];
      if (!sync_mode) begin
        pin_out_next[PIN_RX_FSYNC] = rx_fsync_int;
      end else if (port_ctrl_reg[POS_TX_BUF_SEL]) begin
        pin_out_next[PIN_RX_FSYNC] = tx_buf_enable;
      end else begin
        pin_out_next[PIN_RX_FSYNC] = flag_out_reg[1];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pin_out <= 6'h00;
      pin_oe <= 6'h00;
    end else begin
      pin_out <= pin_out_next;
      pin_oe <= pin_oe_next;
    end
  end

  // ----------------------------------------
  // internal-facing pin values
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rx_fsync_ext <= 1'b0;
      tx_fsync_ext <= 1'b0;
      rx_bclk_ext <= 1'b0;
      rx_clk_sel_ext <= 1'b0;
      tx_clk_sel_ext <= 1'b0;
    end else begin
      // sync mode receivers use tx fsync
      rx_fsync_ext <= sync_mode ? sync2_reg[PIN_TX_FSYNC] : sync2_reg[PIN_RX_FSYNC];
      tx_fsync_ext <= sync2_reg[PIN_TX_FSYNC];
      rx_bclk_ext <= sync2_reg[PIN_RX_BCLK] && !sync_mode;
      rx_clk_sel_ext <= pin_mode_reg[PIN_RX_HFCLK] && !port_ctrl_reg[POS_RX_HF_DIR];
      tx_clk_sel_ext <= pin_mode_reg[PIN_TX_HFCLK] && !port_ctrl_reg[POS_TX_HF_DIR];
    end
  end
endmodule

// File: audio_pin_ctrl_assertions.sv
// concurrent checks on the audio pin control ports
`timescale 1ns/1ps
module audio_pin_ctrl_checker (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [audio_pin_pkg::NUM_PINS-1:0] pin_oe,
  input wire logic rx_clk_sel_ext,
  input wire logic tx_clk_sel_ext
);
  import audio_pin_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  wire acc = psel && penable && pready;
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready held");
  a_err_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
  a_err_high_addr: assert property (acc && paddr > 8'h14 |-> pslverr)
    else $error("unmapped not refused");
  a_ok_addr: assert property (acc && paddr <= 8'h14 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped refused");
  a_unmapped_zero: assert property (acc && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_rdata_stands: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data moved");
  a_rx_src_input: assert property (rx_clk_sel_ext |-> !pin_oe[2])
    else $error("rx clock source while driven");
  a_tx_src_input: assert property (tx_clk_sel_ext |-> !pin_oe[5])
    else $error("tx clock source while driven");
  c_refused: cover property (acc && pslverr);
  c_hf_source: cover property (rx_clk_sel_ext && tx_clk_sel_ext);
  c_fsync_out: cover property (pin_oe[4]);
endmodule
bind audio_pin_ctrl audio_pin_ctrl_checker u_chk (.clk_sys, .reset_n, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .pslverr, .pin_oe, .rx_clk_sel_ext, .tx_clk_sel_ext);

// File: codec_pin_model.sv
// external converter model on the audio port pins
`timescale 1ns/1ps
module codec_pin_model (
  input wire logic link_clk,
  input wire logic [5:0] pin_out,
  input wire logic [5:0] pin_oe,
  input wire logic [5:0] ext_en,
  input wire logic [5:0] ext_val,
  input wire logic hf_src_en,
  output logic [5:0] pin_in
);
  logic [5:0] drv;
  always_comb begin
    drv = ext_val;
    if (hf_src_en) begin
      drv[2] = link_clk;
      drv[5] = link_clk;
    end
  end
  // wire level, pull-down when nobody drives
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & drv);
endmodule

// File: tb_audio_pin_ctrl.sv
// testbench for the audio pin control block
`timescale 1ns/1ps
module tb_audio_pin_ctrl;
  import audio_pin_pkg::*;
  logic clk_sys = 0, link_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, se, hf_src_en = 0, rx_bclk_int = 0, slot_strobe = 0;
  logic rx_fsync_int = 0, tx_fsync_int = 0, tx_buf_enable = 0;
  logic rx_fsync_ext, tx_fsync_ext, rx_bclk_ext, rx_clk_sel_ext, tx_clk_sel_ext;
  logic [5:0] pin_in, pin_out, pin_oe, ext_en = 6'h00, ext_val = 6'h00;
  logic [1:0] lst;
  int err_total = 0, checked = 0, cnt, n;
  always #2.5 clk_sys = ~clk_sys;
  initial begin
    #3.1;
    forever #62.5 link_clk = ~link_clk;
  end
  audio_pin_ctrl u_dut (.clk_sys, .reset_n, .link_clk, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .pin_in, .pin_out, .pin_oe, .rx_fsync_int,
    .tx_fsync_int, .rx_bclk_int, .slot_strobe, .tx_buf_enable, .rx_fsync_ext,
    .tx_fsync_ext, .rx_bclk_ext, .rx_clk_sel_ext, .tx_clk_sel_ext);
  codec_pin_model u_codec (.link_clk, .pin_out, .pin_oe, .ext_en, .ext_val, .hf_src_en,
    .pin_in);
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk_sys) penable <= 1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) err_total++;
    rd = prdata;
    se = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask
  task settle;
    repeat (6) @(posedge clk_sys);
  endtask
  task pulse_fs;
    settle;
    @(posedge clk_sys) tx_fsync_int <= 1;
    @(posedge clk_sys) tx_fsync_int <= 0;
    settle;
  endtask
  task note(input int t);
    $display("test %0d done", t);
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #100000;
    err_total++;
    wrap_up;
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    reset_n <= 1;
    chk({26'h0, pin_oe}, 32'h0);
    rdc(OFS_PIN_MODE, 32'hFFFFFFFF, 32'h0);
    rdc(OFS_GPIO_DIR, 32'hFFFFFFFF, 32'h0);
    note(1);
    wr(OFS_GPIO_DIR, 32'h15);
    wr(OFS_GPIO_OUT, 32'h3F);
    settle;
    chk({26'h0, pin_oe & pin_out}, 32'h15);
    note(2);
    hf_src_en <= 1;
    ext_en <= 6'h24;
    wr(OFS_GPIO_DIR, 32'h0);
    wr(OFS_PIN_MODE, 32'h24);
    settle;
    chk({30'h0, rx_clk_sel_ext, tx_clk_sel_ext}, 32'h3);
    chk({26'h0, pin_oe}, 32'h0);
    rdc(OFS_STATUS, 32'hC, 32'hC);
    note(3);
    hf_src_en <= 0;
    ext_en <= 6'h00;
    wr(OFS_PORT_CTRL, 32'h60);
    settle;
    chk({26'h0, pin_oe}, 32'h24);
    cnt = 0;
    lst = {pin_out[5], pin_out[2]};
    repeat (400) begin
      @(posedge clk_sys);
      if (pin_out[2] !== lst[0]) cnt++;
      if (pin_out[5] !== lst[1]) cnt++;
      lst = {pin_out[5], pin_out[2]};
    end
    chk(32'(cnt >= 14 && cnt <= 18), 32'h1);
    note(4);
    wr(OFS_PIN_MODE, 32'h10);
    wr(OFS_PORT_CTRL, 32'h08);
    tx_fsync_int <= 1;
    settle;
    chk({30'h0, pin_oe[4], pin_out[4]}, 32'h3);
    tx_fsync_int <= 0;
    ext_en <= 6'h10;
    ext_val <= 6'h10;
    wr(OFS_PORT_CTRL, 32'h01);
    settle;
    chk({29'h0, pin_oe[4], tx_fsync_ext, rx_fsync_ext}, 32'h3);
    note(5);
    ext_en <= 6'h01;
    ext_val <= 6'h01;
    wr(OFS_PIN_MODE, 32'h03);
    wr(OFS_PORT_CTRL, 32'h04);
    rx_fsync_int <= 1;
    settle;
    chk({29'h0, pin_oe[1] & pin_out[1], rx_bclk_ext, rx_fsync_ext}, 32'h7);
    rx_fsync_int <= 0;
    note(6);
    wr(OFS_PORT_CTRL, 32'h05);
    wr(OFS_FLAG_CTRL, 32'h02);
    settle;
    chk({31'h0, pin_out[1]}, 32'h0);
    pulse_fs;
    chk({30'h0, pin_oe[1], pin_out[1]}, 32'h3);
    note(7);
    ext_en <= 6'h02;
    ext_val <= 6'h02;
    wr(OFS_PORT_CTRL, 32'h01);
    pulse_fs;
    rdc(OFS_STATUS, 32'h2, 32'h2);
    ext_val <= 6'h00;
    pulse_fs;
    rdc(OFS_STATUS, 32'h2, 32'h0);
    note(8);
    ext_en <= 6'h00;
    wr(OFS_PORT_CTRL, 32'h07);
    tx_buf_enable <= 1;
    settle;
    chk({30'h0, pin_oe[1], pin_out[1]}, 32'h3);
    note(9);
    wr(8'h18, 32'hFFFFFFFF);
    chk({31'h0, se}, 32'h1);
    rdc(8'h18, 32'hFFFFFFFF, 32'h0);
    rdc(OFS_PORT_CTRL, 32'hFF, 32'h07);
    note(10);
    wrap_up;
  end
endmodule
